// ==== hdl/vcm_pkg.sv ====
package vcm_pkg;

	// ----------------------------------------------------------------
	// Data and buffer sizes
	// ----------------------------------------------------------------
	localparam int DW        = 9;
	localparam int EOP_BIT   = 8;
	localparam int FRAME_MAX = 256;
	localparam int TX_DEPTH  = FRAME_MAX;
	localparam int RX_DEPTH  = 2 * FRAME_MAX;
	localparam int STG_DEPTH = 16;
	localparam int TOK_MAX   = RX_DEPTH / FRAME_MAX;
	localparam int TOKW      = 2;
	localparam int CRW       = 8;

	// ----------------------------------------------------------------
	// Time-slots
	// ----------------------------------------------------------------
	localparam int TIME_W     = 32;
	localparam int NSLOT      = 8;
	localparam int SLW        = 3;
	localparam int SLOT_SHIFT = 8;

	// ----------------------------------------------------------------
	// Precedence values
	// ----------------------------------------------------------------
	localparam int PW = 8;
	localparam logic [PW-1:0] PREC_URGENT    = 8'hff;
	localparam logic [PW-1:0] PREC_SLOT      = 8'hfe;
	localparam logic [PW-1:0] PREC_NONE      = 8'h00;
	localparam logic [PW-1:0] PREC_PRIO_BASE = 8'h40;
	localparam logic [PW-1:0] PREC_PRIO_STEP = 8'h30;
	localparam logic [PW-1:0] PREC_BW_BASE   = 8'h10;
	localparam logic [1:0]    PRIO_URGENT    = 2'h3;
	localparam int            BW_ACC_W       = 12;
	localparam logic [11:0]   BW_ACC_RST     = 12'h800;

	// ----------------------------------------------------------------
	// Service policies
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		QOS_BEST,
		QOS_PRIO,
		QOS_BW,
		QOS_SCHED
	} vcm_qos_t;

endpackage

// ==== hdl/vcm_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module vcm_fifo #(
	parameter  int W     = 9,
	parameter  int DEPTH = 16,
	localparam int AW    = $clog2(DEPTH),
	localparam int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          in_valid,
	input  wire logic [W-1:0]  in_data,
	output logic               in_ready,
	output logic               out_valid,
	output logic [W-1:0]       out_data,
	input  wire logic          out_ready,
	output logic [CW-1:0]      count
);
	// Depth must be a power of two; head word sits in an output register
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
	logic [CW-1:0] cnt_ff, nxt_cnt, mem_cnt;
	logic [W-1:0]  dat_ff, nxt_dat;
	logic          vld_ff, nxt_vld, rdy_ff, nxt_rdy;
	logic          push, pop, load, wen;

	always_comb begin
		push     = in_valid & rdy_ff;
		pop      = vld_ff & out_ready;
		load     = ~vld_ff | pop;
		mem_cnt  = cnt_ff - CW'(vld_ff);
		nxt_wptr = wptr_ff;
		nxt_rptr = rptr_ff;
		nxt_dat  = dat_ff;
		nxt_vld  = vld_ff;
		wen      = push & ~(load & (mem_cnt == '0));
		if (load) begin
			if (mem_cnt != '0) begin
				nxt_dat  = mem[rptr_ff];
				nxt_rptr = rptr_ff + AW'(1);
				nxt_vld  = 1'b1;
			end else begin
				nxt_dat = in_data;
				nxt_vld = push;
			end
		end
		if (wen) begin
			nxt_wptr = wptr_ff + AW'(1);
		end
		nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
		nxt_rdy = nxt_cnt != CW'(DEPTH);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff  <= '0;
			dat_ff  <= '0;
			vld_ff  <= 1'b0;
			rdy_ff  <= 1'b1;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			cnt_ff  <= nxt_cnt;
			dat_ff  <= nxt_dat;
			vld_ff  <= nxt_vld;
			rdy_ff  <= nxt_rdy;
		end
	end

	always_ff @(posedge clk) begin
		if (wen) begin
			mem[wptr_ff] <= in_data;
		end
	end

	assign in_ready  = rdy_ff;
	assign out_valid = vld_ff;
	assign out_data  = dat_ff;
	assign count     = cnt_ff;
endmodule
`default_nettype wire

// ==== hdl/vcm_prec.sv ====
`timescale 1ns/1ps
`default_nettype none
module vcm_prec (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire vcm_pkg::vcm_qos_t      qos,
	input  wire logic [1:0]             prio_lvl,
	input  wire logic [7:0]             bw_resv,
	input  wire logic [7:0]             exp_bw,
	input  wire logic                   slot_on,
	input  wire logic                   word_sent,
	input  wire logic                   waiting,
	output logic [vcm_pkg::PW-1:0]      prec
);
	import vcm_pkg::*;

	logic [BW_ACC_W-1:0] acc_ff, nxt_acc;
	logic [PW-1:0]       prec_ff, nxt_prec;
	logic [BW_ACC_W:0]   sum;

	always_comb begin
		sum     = '0;
		nxt_acc = acc_ff;
		// Sending drains the share, waiting refills it
		if (word_sent) begin
			sum     = {1'b0, acc_ff} - {5'h00, 8'hff - bw_resv};
			nxt_acc = sum[BW_ACC_W] ? '0 : sum[BW_ACC_W-1:0];
		end else if (waiting) begin
			sum     = {1'b0, acc_ff} + {5'h00, bw_resv};
			nxt_acc = sum[BW_ACC_W] ? '1 : sum[BW_ACC_W-1:0];
		end
		unique case (qos)
			QOS_PRIO: begin
				if (prio_lvl == PRIO_URGENT) begin
					nxt_prec = PREC_URGENT;
				end else begin
					nxt_prec = PREC_PRIO_BASE + PW'(prio_lvl * PREC_PRIO_STEP);
				end
			end
			QOS_BW: nxt_prec = PREC_BW_BASE + {1'b0, acc_ff[BW_ACC_W-1 -: 7]};
			QOS_SCHED: nxt_prec = slot_on ? PREC_SLOT : PREC_NONE;
			QOS_BEST: nxt_prec = {4'h0, exp_bw[7:4]};
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_ff  <= BW_ACC_RST;
			prec_ff <= PREC_NONE;
		end else begin
			acc_ff  <= nxt_acc;
			prec_ff <= nxt_prec;
		end
	end

	assign prec = prec_ff;
endmodule
`default_nettype wire

// ==== hdl/vcm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module vcm_top #(
	parameter  int NVC = 4,
	localparam int VCW = $clog2(NVC)
) (
	input  wire logic                            clk,
	input  wire logic                            resetn,
	input  wire logic [NVC-1:0]                  tx_valid,
	input  wire logic [NVC*vcm_pkg::DW-1:0]      tx_data,
	output logic      [NVC-1:0]                  tx_ready,
	output logic      [NVC-1:0]                  rx_valid,
	output logic      [NVC*vcm_pkg::DW-1:0]      rx_data,
	input  wire logic [NVC-1:0]                  rx_ready,
	output logic                                 frm_valid,
	output logic      [vcm_pkg::DW-1:0]          frm_data,
	output logic      [VCW-1:0]                  frm_vc,
	output logic                                 frm_last,
	input  wire logic                            frm_ready,
	input  wire logic                            in_valid,
	input  wire logic [vcm_pkg::DW-1:0]          in_data,
	input  wire logic [VCW-1:0]                  in_vc,
	input  wire logic                            in_last,
	output logic      [NVC-1:0]                  in_ready,
	output logic                                 crd_out_valid,
	output logic      [VCW-1:0]                  crd_out_vc,
	input  wire logic                            crd_out_ready,
	input  wire logic                            crd_in_valid,
	input  wire logic [VCW-1:0]                  crd_in_vc,
	input  wire logic [NVC*2-1:0]                qos,
	input  wire logic [NVC*2-1:0]                prio_lvl,
	input  wire logic [NVC*8-1:0]                bw_resv,
	input  wire logic [NVC*8-1:0]                exp_bw,
	input  wire logic [NVC*vcm_pkg::NSLOT-1:0]   sched_map,
	input  wire logic                            slot_src,
	input  wire logic                            time_load,
	input  wire logic [vcm_pkg::TIME_W-1:0]      time_value,
	input  wire logic                            sync_pulse,
	output logic      [NVC-1:0]                  credit_ok
);
	import vcm_pkg::*;

	localparam int TCW = $clog2(TX_DEPTH + 1);
	localparam int RCW = $clog2(RX_DEPTH + 1);
	localparam int SW  = 1 + VCW + DW;

	typedef enum logic {ST_IDLE, ST_SEND} vcm_state_t;

	logic [DW-1:0]  tx_head [NVC];
	logic [TCW-1:0] tx_cnt [NVC];
	logic [RCW-1:0] rx_cnt [NVC];
	logic [PW-1:0]  prec [NVC];
	logic [NVC-1:0] tx_hv, tx_pop, rx_push, in_done, slot_on, is_sched, elig, waiting;
	logic [SW-1:0]  stg_in, stg_out;
	logic           stg_rdy, do_pop, cur_last, cur_ok, grant, found;
	logic [VCW-1:0] best_vc;
	logic [PW-1:0]  best_p;

	// ----------------------------------------------------------------
	// Channel buffer pairs
	// ----------------------------------------------------------------
	for (genvar c = 0; c < NVC; c++) begin : g_vc
		vcm_fifo #(.W(DW), .DEPTH(TX_DEPTH)) u_txb (
			.clk       (clk),
			.resetn    (resetn),
			.in_valid  (tx_valid[c]),
			.in_data   (tx_data[c*DW +: DW]),
			.in_ready  (tx_ready[c]),
			.out_valid (tx_hv[c]),
			.out_data  (tx_head[c]),
			.out_ready (tx_pop[c]),
			.count     (tx_cnt[c])
		);
		vcm_fifo #(.W(DW), .DEPTH(RX_DEPTH)) u_rxb (
			.clk       (clk),
			.resetn    (resetn),
			.in_valid  (rx_push[c]),
			.in_data   (in_data),
			.in_ready  (in_ready[c]),
			.out_valid (rx_valid[c]),
			.out_data  (rx_data[c*DW +: DW]),
			.out_ready (rx_ready[c]),
			.count     (rx_cnt[c])
		);
		vcm_prec u_prec (
			.clk       (clk),
			.resetn    (resetn),
			.qos       (vcm_qos_t'(qos[c*2 +: 2])),
			.prio_lvl  (prio_lvl[c*2 +: 2]),
			.bw_resv   (bw_resv[c*8 +: 8]),
			.exp_bw    (exp_bw[c*8 +: 8]),
			.slot_on   (slot_on[c]),
			.word_sent (tx_pop[c]),
			.waiting   (waiting[c]),
			.prec      (prec[c])
		);
	end

	// Frame words land in their channel in arrival order
	always_comb begin
		for (int c = 0; c < NVC; c++) begin
			rx_push[c] = in_valid & (in_vc == VCW'(c));
			in_done[c] = rx_push[c] & in_ready[c] & in_last;
		end
	end

	// ----------------------------------------------------------------
	// Credit send controller
	// ----------------------------------------------------------------
	logic [TOKW-1:0] tok_ff [NVC];
	logic [TOKW-1:0] nxt_tok [NVC];
	logic            cov_ff, nxt_cov, picked;
	logic [VCW-1:0]  cvc_ff, nxt_cvc;

	always_comb begin
		nxt_cov = cov_ff;
		nxt_cvc = cvc_ff;
		picked  = 1'b0;
		for (int c = 0; c < NVC; c++) begin
			nxt_tok[c] = tok_ff[c] - TOKW'(in_done[c] && tok_ff[c] != '0);
		end
		if (!cov_ff || crd_out_ready) begin
			nxt_cov = 1'b0;
			// Partly filled frames count twice: conservative, never overruns
			for (int c = 0; c < NVC; c++) begin
				if (!picked && int'(rx_cnt[c]) + (int'(tok_ff[c]) + 1) * FRAME_MAX <= RX_DEPTH) begin
					picked     = 1'b1;
					nxt_cov    = 1'b1;
					nxt_cvc    = VCW'(c);
					nxt_tok[c] = nxt_tok[c] + TOKW'(1);
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cov_ff <= 1'b0;
			cvc_ff <= '0;
			for (int c = 0; c < NVC; c++) begin
				tok_ff[c] <= '0;
			end
		end else begin
			cov_ff <= nxt_cov;
			cvc_ff <= nxt_cvc;
			tok_ff <= nxt_tok;
		end
	end

	// ----------------------------------------------------------------
	// Credit receive controller
	// ----------------------------------------------------------------
	logic [CRW-1:0] crd_ff [NVC];
	logic [CRW-1:0] nxt_crd [NVC];
	logic [NVC-1:0] cok_ff, nxt_cok;

	always_comb begin
		for (int c = 0; c < NVC; c++) begin
			nxt_crd[c] = crd_ff[c];
			if (crd_in_valid && crd_in_vc == VCW'(c) && crd_ff[c] != '1) begin
				nxt_crd[c] = nxt_crd[c] + CRW'(1);
			end
			if (grant && best_vc == VCW'(c)) begin
				nxt_crd[c] = nxt_crd[c] - CRW'(1);
			end
			nxt_cok[c] = nxt_crd[c] != '0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cok_ff <= '0;
			for (int c = 0; c < NVC; c++) begin
				crd_ff[c] <= '0;
			end
		end else begin
			cok_ff <= nxt_cok;
			crd_ff <= nxt_crd;
		end
	end

	// ----------------------------------------------------------------
	// Time-slots
	// ----------------------------------------------------------------
	logic [TIME_W-1:0] time_ff, nxt_time;
	logic [SLW-1:0]    sync_slot_ff, nxt_sync_slot, slot;

	always_comb begin
		nxt_time      = time_load ? time_value : time_ff + TIME_W'(1);
		nxt_sync_slot = sync_slot_ff + SLW'(sync_pulse);
		slot          = slot_src ? sync_slot_ff : time_ff[SLOT_SHIFT +: SLW];
		for (int c = 0; c < NVC; c++) begin
			is_sched[c] = vcm_qos_t'(qos[c*2 +: 2]) == QOS_SCHED;
			slot_on[c]  = sched_map[c*NSLOT + int'(slot)];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			time_ff      <= '0;
			sync_slot_ff <= '0;
		end else begin
			time_ff      <= nxt_time;
			sync_slot_ff <= nxt_sync_slot;
		end
	end

	// ----------------------------------------------------------------
	// Medium access control
	// ----------------------------------------------------------------
	vcm_state_t     state_ff, nxt_state;
	logic [VCW-1:0] sel_ff, nxt_sel;
	logic [7:0]     wcnt_ff, nxt_wcnt;

	always_comb begin
		found   = 1'b0;
		best_vc = '0;
		best_p  = PREC_NONE;
		for (int c = 0; c < NVC; c++) begin
			// A scheduled channel out of its slot leaves room for others
			elig[c] = tx_hv[c] & (crd_ff[c] != '0) & (~is_sched[c] | slot_on[c]);
			// Strict compare keeps the lowest index on a tie
			if (elig[c] && (!found || prec[c] > best_p)) begin
				found   = 1'b1;
				best_vc = VCW'(c);
				best_p  = prec[c];
			end
		end
		grant    = (state_ff == ST_IDLE) & found;
		// A frame whose slot closes stalls until that channel's next slot
		cur_ok   = ~is_sched[sel_ff] | slot_on[sel_ff];
		cur_last = (wcnt_ff == 8'(FRAME_MAX - 1)) | (tx_cnt[sel_ff] == TCW'(1));
		do_pop   = (state_ff == ST_SEND) & tx_hv[sel_ff] & cur_ok & stg_rdy;
		stg_in   = {cur_last, sel_ff, tx_head[sel_ff]};
		for (int c = 0; c < NVC; c++) begin
			tx_pop[c]  = do_pop & (sel_ff == VCW'(c));
			waiting[c] = elig[c] & (state_ff == ST_SEND) & (sel_ff != VCW'(c));
		end
		nxt_state = state_ff;
		nxt_sel   = sel_ff;
		nxt_wcnt  = wcnt_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (found) begin
					nxt_state = ST_SEND;
					nxt_sel   = best_vc;
					nxt_wcnt  = '0;
				end
			end
			ST_SEND: begin
				if (do_pop) begin
					nxt_wcnt = wcnt_ff + 8'h01;
					if (cur_last) begin
						nxt_state = ST_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
			sel_ff   <= '0;
			wcnt_ff  <= '0;
		end else begin
			state_ff <= nxt_state;
			sel_ff   <= nxt_sel;
			wcnt_ff  <= nxt_wcnt;
		end
	end

	vcm_fifo #(.W(SW), .DEPTH(STG_DEPTH)) u_stg (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (do_pop),
		.in_data   (stg_in),
		.in_ready  (stg_rdy),
		.out_valid (frm_valid),
		.out_data  (stg_out),
		.out_ready (frm_ready),
		.count     ()
	);

	assign frm_data      = stg_out[DW-1:0];
	assign frm_vc        = stg_out[DW +: VCW];
	assign frm_last      = stg_out[SW-1];
	assign crd_out_valid = cov_ff;
	assign crd_out_vc    = cvc_ff;
	assign credit_ok     = cok_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic beaten, tie_lower;
	always_comb begin
		beaten    = 1'b0;
		tie_lower = 1'b0;
		for (int c = 0; c < NVC; c++) begin
			beaten    = beaten | (elig[c] & (prec[c] > best_p));
			tie_lower = tie_lower | (elig[c] & (prec[c] == best_p) & (VCW'(c) < best_vc));
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_highest;
		grant |-> !beaten && !tie_lower;
	endproperty
	a_highest: assert property (p_highest) else $error("grant not to best channel");

	property p_seg_len;
		do_pop && wcnt_ff == 8'hff |-> cur_last ##1 state_ff == ST_IDLE;
	endproperty
	a_seg_len: assert property (p_seg_len) else $error("segment exceeds frame limit");

	property p_grant_cred;
		grant |=> state_ff == ST_SEND && crd_ff[sel_ff] == $past(crd_ff[best_vc]) - 8'h01
			+ 8'($past(crd_in_valid && crd_in_vc == best_vc));
	endproperty
	a_grant_cred: assert property (p_grant_cred) else $error("grant did not take credit");

	property p_sched_slot;
		(tx_pop & is_sched & ~slot_on) == '0;
	endproperty
	a_sched_slot: assert property (p_sched_slot) else $error("scheduled send outside slot");

	property p_urgent;
		(qos[5:4] == 2'h1 && prio_lvl[5:4] == PRIO_URGENT) [*2] |-> prec[2] == PREC_URGENT;
	endproperty
	a_urgent: assert property (p_urgent) else $error("urgent level precedence wrong");

	property p_slot_prec;
		(qos[1:0] == 2'h3 && slot_on[0]) ##1 (qos[1:0] == 2'h3) |-> prec[0] == PREC_SLOT;
	endproperty
	a_slot_prec: assert property (p_slot_prec) else $error("slot precedence wrong");

	property p_tok_hold;
		crd_out_valid && !crd_out_ready |=> crd_out_valid && $stable(crd_out_vc);
	endproperty
	a_tok_hold: assert property (p_tok_hold) else $error("token dropped before taken");

	property p_tok_room;
		int'(tok_ff[1]) * FRAME_MAX + int'(rx_cnt[1]) <= RX_DEPTH + FRAME_MAX && tok_ff[1] <= TOKW'(TOK_MAX);
	endproperty
	a_tok_room: assert property (p_tok_room) else $error("tokens exceed buffer room");

	property p_rx_order;
		rx_push[1] && in_ready[1] && !rx_valid[1] && rx_cnt[1] == '0 |=> rx_valid[1] && rx_data[DW +: DW] == $past(in_data);
	endproperty
	a_rx_order: assert property (p_rx_order) else $error("received word not delivered");

	c_full_frame: cover property (do_pop && wcnt_ff == 8'hff);
	c_back2back: cover property (do_pop && cur_last ##1 grant);
	c_stg_full: cover property (!stg_rdy);
	c_tie: cover property (grant && elig[0] && elig[1] && prec[0] == prec[1]);
endmodule
`default_nettype wire

// ==== testbench/vcm_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module vcm_far_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       slow,
	input  wire logic       frm_valid,
	input  wire logic [8:0] frm_data,
	input  wire logic [1:0] frm_vc,
	input  wire logic       frm_last,
	output logic            frm_ready,
	input  wire logic       crd_out_valid,
	input  wire logic [1:0] crd_out_vc,
	output logic            crd_out_ready
);
	logic [2:0] ph_ff;
	logic [8:0] w_q[$];
	logic [1:0] vc_q[$];
	int         len_q[$];
	int         len;
	int         tok[4];

	// ------------------------------------------------------------
	// Framing sink and token receiver
	// ------------------------------------------------------------
	// Slow mode takes one word in eight, so the staging fifo backs up
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ph_ff <= 3'h0;
			frm_ready <= 1'b0;
			crd_out_ready <= 1'b0;
			len = 0;
			tok = '{default: 0};
		end else begin
			ph_ff <= ph_ff + 3'h1;
			frm_ready <= !slow || ph_ff == 3'h7;
			crd_out_ready <= ph_ff[0];
			if (frm_valid && frm_ready) begin
				w_q.push_back(frm_data);
				len++;
				if (frm_last) begin
					vc_q.push_back(frm_vc);
					len_q.push_back(len);
					len = 0;
				end
			end
			if (crd_out_valid && crd_out_ready) begin
				tok[crd_out_vc]++;
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, resetn, slow, frm_valid, frm_last, frm_ready, in_valid, in_last;
	logic        crd_out_valid, crd_out_ready, crd_in_valid, slot_src, time_load, sync_pulse;
	logic [3:0]  tx_valid, tx_ready, rx_valid, rx_ready, in_ready, credit_ok;
	logic [35:0] tx_data, rx_data;
	logic [8:0]  frm_data, in_data;
	logic [1:0]  frm_vc, in_vc, crd_out_vc, crd_in_vc;
	logic [7:0]  qos, prio_lvl;
	logic [31:0] bw_resv, exp_bw, sched_map, time_value;
	int          err_total, n_compared, i, k;

	vcm_top dut_u (.clk(clk), .resetn(resetn), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .frm_valid(frm_valid),
		.frm_data(frm_data), .frm_vc(frm_vc), .frm_last(frm_last), .frm_ready(frm_ready),
		.in_valid(in_valid), .in_data(in_data), .in_vc(in_vc), .in_last(in_last), .in_ready(in_ready),
		.crd_out_valid(crd_out_valid), .crd_out_vc(crd_out_vc), .crd_out_ready(crd_out_ready),
		.crd_in_valid(crd_in_valid), .crd_in_vc(crd_in_vc), .qos(qos), .prio_lvl(prio_lvl),
		.bw_resv(bw_resv), .exp_bw(exp_bw), .sched_map(sched_map), .slot_src(slot_src),
		.time_load(time_load), .time_value(time_value), .sync_pulse(sync_pulse), .credit_ok(credit_ok));

	vcm_far_model far_u (.clk(clk), .resetn(resetn), .slow(slow), .frm_valid(frm_valid),
		.frm_data(frm_data), .frm_vc(frm_vc), .frm_last(frm_last), .frm_ready(frm_ready),
		.crd_out_valid(crd_out_valid), .crd_out_vc(crd_out_vc), .crd_out_ready(crd_out_ready));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Checks, report and access tasks
	// ------------------------------------------------------------
	task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("errors=%0d compared=%0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic give_up;
		err_total++;
		final_report();
	endtask

	task automatic push(input logic [3:0] m, input logic [8:0] d);
		@(negedge clk);
		for (k = 0; k < 1000 && (tx_ready & m) != m; k++) @(negedge clk);
		if (k == 1000) give_up();
		tx_valid = m;
		tx_data = {4{d}};
		@(negedge clk);
		tx_valid = 4'h0;
		tx_data = ~tx_data;
	endtask

	task automatic credit(input logic [3:0] m);
		for (int c = 0; c < 4; c++) begin
			if (m[c]) begin
				@(negedge clk);
				crd_in_valid = 1'b1;
				crd_in_vc = 2'(c);
				@(negedge clk);
				crd_in_valid = 1'b0;
			end
		end
	endtask

	task automatic wait_frames(input int n);
		for (k = 0; k < 5000 && far_u.vc_q.size() < n; k++) @(negedge clk);
		if (k == 5000) give_up();
	endtask

	task automatic clear_q;
		far_u.w_q.delete();
		far_u.vc_q.delete();
		far_u.len_q.delete();
	endtask

	// One-word packets on every channel in m; frames must leave in order ord
	task automatic race(input logic [3:0] m, input logic [7:0] ord, input int n);
		credit(m);
		push(m, 9'h1a5);
		wait_frames(n);
		for (i = 0; i < n; i++) chk_num(far_u.vc_q[i], ord[i*2+:2]);
		clear_q();
	endtask

	function automatic logic [8:0] seg_w(input int n);
		if (n < 256) begin
			return {n == 255, 8'(n)};
		end
		return {n == 299, 8'(n - 256)};
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{err_total, n_compared, slow, tx_valid, tx_data, rx_ready, in_valid, in_data, in_last} = '0;
		{crd_in_valid, crd_in_vc, qos, prio_lvl, bw_resv, exp_bw, sched_map, slot_src} = '0;
		{time_load, time_value, sync_pulse, resetn} = '0;
		in_vc = 2'h1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		chk_num({tx_ready, in_ready, rx_valid, credit_ok}, 32'hff00);
		for (k = 0; k < 200 && far_u.tok[3] < 2; k++) @(negedge clk);
		for (i = 0; i < 4; i++) chk_num(far_u.tok[i], 2);
		// No credit yet: a full buffer must refuse and stay off the link
		for (i = 0; i < 256; i++) push(4'h1, seg_w(i));
		chk_num({tx_ready[0], credit_ok[0], frm_valid}, 0);
		slow = 1'b1;
		credit(4'h1);
		credit(4'h1);
		for (i = 256; i < 300; i++) push(4'h1, seg_w(i));
		wait_frames(2);
		chk_num(far_u.len_q[0], 256);
		chk_num(far_u.len_q[1], 44);
		for (i = 0; i < 300; i++) chk_word(far_u.w_q[i], seg_w(i));
		clear_q();
		slow = 1'b0;
		for (i = 0; i < 512; i++) begin
			@(negedge clk);
			for (k = 0; k < 100 && !in_ready[1]; k++) @(negedge clk);
			if (k == 100) give_up();
			in_valid = 1'b1;
			in_data = {i == 511, 8'(i * 7)};
			in_last = i[7:0] == 8'hff;
			@(negedge clk);
			in_valid = 1'b0;
			in_data = ~in_data;
		end
		chk_num({in_ready[1], 8'(far_u.tok[1])}, 2);
		for (i = 0; i < 512; i++) begin
			@(negedge clk);
			for (k = 0; k < 100 && !rx_valid[1]; k++) @(negedge clk);
			if (k == 100) give_up();
			chk_word(rx_data[17:9], {i == 511, 8'(i * 7)});
			rx_ready[1] = 1'b1;
			@(negedge clk);
			rx_ready[1] = 1'b0;
		end
		for (k = 0; k < 200 && far_u.tok[1] < 4; k++) @(negedge clk);
		chk_num(far_u.tok[1], 4);
		qos = 8'h54;
		prio_lvl = 8'h34;
		race(4'hf, 8'h36, 4);
		qos = 8'h55;
		prio_lvl = 8'h55;
		race(4'hf, 8'he4, 4);
		qos = 8'h00;
		exp_bw = 32'hf0801000;
		race(4'hf, 8'h1b, 4);
		qos = 8'h08;
		bw_resv = 32'h00008000;
		exp_bw = 32'h000000f0;
		race(4'h3, 8'h01, 2);
		// Channel 0 scheduled in slot 1 only, slot taken from local time
		qos = 8'h07;
		prio_lvl = 8'h0c;
		sched_map = 32'h2;
		time_load = 1'b1;
		@(negedge clk);
		time_load = 1'b0;
		credit(4'h9);
		push(4'h9, 9'h1a5);
		wait_frames(1);
		chk_num(far_u.vc_q.pop_front(), 3);
		repeat (100) @(negedge clk);
		chk_num(far_u.vc_q.size(), 0);
		time_value = 32'h100;
		time_load = 1'b1;
		@(negedge clk);
		time_load = 1'b0;
		wait_frames(1);
		chk_num(far_u.vc_q.pop_front(), 0);
		clear_q();
		race(4'hb, 8'h31, 3);
		// Slot from the sync counter, still at slot 0
		slot_src = 1'b1;
		credit(4'h1);
		push(4'h1, 9'h1a5);
		repeat (50) @(negedge clk);
		chk_num(far_u.vc_q.size(), 0);
		sync_pulse = 1'b1;
		@(negedge clk);
		sync_pulse = 1'b0;
		wait_frames(1);
		chk_num(far_u.vc_q.pop_front(), 0);
		final_report();
	end
endmodule
`default_nettype wire
